// File: rtl/spmc_params.svh
/*
 Constants for the stop/idle/sleep sequencer: register offsets, field positions,
 reset values and warm-up counts. Assumes inclusion from the top module only; the package does not include it.
*/
`ifndef SPMC_PARAMS_SVH
`define SPMC_PARAMS_SVH
// Register byte offsets
`define SPMC_SYSCTL1_ADDR   4'h0
`define SPMC_SYSCTL2_ADDR   4'h4
`define SPMC_WKEN_ADDR      4'h8
`define SPMC_STATUS_ADDR    4'hC
// First system control fields
`define SPMC_STOP_BIT       7
`define SPMC_RELEASE_LEVEL_SELECT_BIT       6
`define SPMC_RETM_BIT       5
`define SPMC_WUT_HI         3
`define SPMC_WUT_LO         2
// Second system control fields
`define SPMC_XEN_BIT        7
`define SPMC_XTEN_BIT       6
`define SPMC_SYSCK_BIT      5
`define SPMC_IDLE_BIT       4
// Reset values
`define SPMC_SYSCTL1_RST    8'h00
`define SPMC_SYSCTL2_RST    8'h80
`define SPMC_WKEN_RST       4'h0
// Warm-up counts in oscillator cycles: fast then slow, codes 00..11
`define SPMC_WU_F0          18'h3_0000
`define SPMC_WU_F1          18'h1_0000
`define SPMC_WU_F2          18'h0_C000
`define SPMC_WU_F3          18'h0_4000
`define SPMC_WU_S0          18'h0_6000
`define SPMC_WU_S1          18'h0_2000
`define SPMC_WU_S2          18'h0_00C0
`define SPMC_WU_S3          18'h0_0040
`endif

// File: rtl/spmc_pkg.sv
/*
 Types of the stop/idle/sleep sequencer.
 Assumes the params header sits beside it.
*/
package spmc_pkg;
   // Power states, one-hot
   typedef enum logic [4:0] {
      SPMC_RUN    = 5'b00001,
      SPMC_STOP   = 5'b00010,
      SPMC_WARMUP = 5'b00100,
      SPMC_HALT   = 5'b01000,
      SPMC_ISR    = 5'b10000
   } spmc_state_t;
endpackage : spmc_pkg

// File: rtl/spmc_ctrl.sv
/*
 Stop, idle and sleep mode sequencer with a classic Wishbone register slave.
 Assumes wake inputs synchronous to clk_i and an oscillator tick (osc_tick_i)
 that pulses once per cycle of the clock being warmed up.
*/
`timescale 1ns/1ps
`include "spmc_params.svh"
module spmc_ctrl #(
   parameter int KEYS = 4
) (
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   // Wishbone slave
   input  wire logic              cyc_i,
   input  wire logic              stb_i,
   input  wire logic              we_i,
   input  wire logic [3:0]        adr_i,
   input  wire logic [3:0]        sel_i,
   input  wire logic [31:0]       dat_i,
   output logic      [31:0]       dat_o,
   output logic                   ack_o,
   // Wake sources
   input  wire logic              wake_pin_i,
   input  wire logic [KEYS-1:0]   key_wakeup_inputs_i,
   input  wire logic              irq_req_i,
   input  wire logic              master_interrupt_enable_i,
   input  wire logic              osc_tick_i,
   // Core controls
   input  wire logic [15:0]       entry_pc_i,
   output logic                   cpu_halt_o,
   output logic                   wdt_halt_o,
   output logic                   periph_halt_o,
   output logic                   divider_clear_o,
   output logic                   service_irq_o,
   output logic                   fast_osc_en_o,
   output logic                   slow_osc_en_o,
   output logic [15:0]            held_pc_o,
   output spmc_pkg::spmc_state_t  state_o
);
   import spmc_pkg::*;

   typedef struct packed {
      spmc_state_t  st;
      logic [7:0]   ctl1;
      logic [7:0]   ctl2;
      logic [3:0]   wken;
      logic         release_level_select_eff;
      logic         wake_s1;
      logic         wake_s2;
      logic         wake_d;
      logic [KEYS-1:0] key_s1;
      logic [KEYS-1:0] key_s2;
      logic [17:0]  cnt;
      logic [15:0]  pc;
      logic [31:0]  dat;
      logic         ack;
      logic         clr;
      logic         svc;
      logic         xen;
      logic         xten;
      logic         halt;
      logic         phalt;
   } spmc_regs_t;

   spmc_regs_t r_reg, r_next;

   // Warm-up count for select code and return mode
   function automatic logic [17:0] wu_count(input logic [1:0] sel, input logic slow);
      logic [17:0] c;
      c = '0;
      unique case ({slow, sel})
         3'b000: c = `SPMC_WU_F0;
         3'b001: c = `SPMC_WU_F1;
         3'b010: c = `SPMC_WU_F2;
         3'b011: c = `SPMC_WU_F3;
         3'b100: c = `SPMC_WU_S0;
         3'b101: c = `SPMC_WU_S1;
         3'b110: c = `SPMC_WU_S2;
         3'b111: c = `SPMC_WU_S3;
      endcase
      return c;
   endfunction : wu_count

   logic wake_rise, level_wake, key_wake, release_c, acc, wr;

   always_comb begin
      r_next     = r_reg;
      r_next.ack = 1'b0;
      r_next.clr = 1'b0;
      r_next.svc = 1'b0;
      // Two-stage synchronisers; stage two feeds logic, plus the wake_d delay stage for the wake rise
      r_next.wake_s1 = wake_pin_i;
      r_next.wake_s2 = r_reg.wake_s1;
      r_next.wake_d  = r_reg.wake_s2;
      r_next.key_s1  = key_wakeup_inputs_i;
      r_next.key_s2  = r_reg.key_s1;
      wake_rise  = r_reg.wake_s2 & ~r_reg.wake_d;
      // Keys are active low; only enabled ones count
      key_wake   = |(~r_reg.key_s2 & r_reg.wken[KEYS-1:0]);
      level_wake = r_reg.wake_s2 | key_wake;
      release_c  = r_reg.release_level_select_eff ? level_wake : wake_rise;
      // Pending level selection takes effect only on a wake rise
      if (!r_reg.ctl1[`SPMC_RELEASE_LEVEL_SELECT_BIT])
         r_next.release_level_select_eff = 1'b0;
      else if (wake_rise)
         r_next.release_level_select_eff = 1'b1;
      // Bus slave: single-cycle ack, dropped the cycle after
      acc = cyc_i & stb_i & ~r_reg.ack;
      wr  = acc & we_i & sel_i[0];
      if (acc) begin
         r_next.ack = 1'b1;
         unique case (adr_i)
            `SPMC_SYSCTL1_ADDR: r_next.dat = {24'h00_0000, r_reg.ctl1[7:2], 2'b00};
            `SPMC_SYSCTL2_ADDR: r_next.dat = {24'h00_0000, r_reg.ctl2[7:4], 4'h0};
            `SPMC_WKEN_ADDR:    r_next.dat = {28'h000_0000, r_reg.wken};
            `SPMC_STATUS_ADDR:  r_next.dat = {27'h000_0000, r_reg.st};
            default:            r_next.dat = 32'h0000_0000;
         endcase
      end
      if (wr && adr_i == `SPMC_SYSCTL1_ADDR)
         r_next.ctl1 = {dat_i[7:2], 2'b00};
      if (wr && adr_i == `SPMC_SYSCTL2_ADDR)
         r_next.ctl2 = {dat_i[7:4], 4'h0};
      if (wr && adr_i == `SPMC_WKEN_ADDR)
         r_next.wken = dat_i[3:0];
      // Power state machine
      unique case (r_reg.st)
         SPMC_RUN: begin
            if (r_reg.ctl1[`SPMC_STOP_BIT]) begin
               r_next.pc = entry_pc_i + 16'h0002;
               if (r_reg.release_level_select_eff && level_wake) begin
                  r_next.st  = SPMC_WARMUP;
                  r_next.cnt = wu_count(r_reg.ctl1[`SPMC_WUT_HI:`SPMC_WUT_LO], r_reg.ctl1[`SPMC_RETM_BIT]);
               end else begin
                  r_next.st   = SPMC_STOP;
                  r_next.xen  = 1'b0;
                  r_next.xten = 1'b0;
               end
            end else if (r_reg.ctl2[`SPMC_IDLE_BIT]) begin
               r_next.st = SPMC_HALT;
               r_next.pc = entry_pc_i + 16'h0002;
            end else begin
               r_next.xen  = r_reg.ctl2[`SPMC_XEN_BIT];
               r_next.xten = r_reg.ctl2[`SPMC_XTEN_BIT];
            end
         end
         SPMC_STOP: begin
            r_next.clr = 1'b1;
            if (release_c) begin
               r_next.st  = SPMC_WARMUP;
               r_next.cnt = wu_count(r_reg.ctl1[`SPMC_WUT_HI:`SPMC_WUT_LO], r_reg.ctl1[`SPMC_RETM_BIT]);
               // Fast return in dual mode wakes both; slow return only the slow one
               if (r_reg.ctl1[`SPMC_RETM_BIT]) begin
                  r_next.xen  = 1'b0;
                  r_next.xten = 1'b1;
               end else begin
                  r_next.xen  = 1'b1;
                  r_next.xten = r_reg.ctl2[`SPMC_XTEN_BIT];
               end
            end
         end
         SPMC_WARMUP: begin
            // Wake pin state no longer matters here
            r_next.clr = 1'b1;
            if (osc_tick_i) begin
               r_next.cnt = r_reg.cnt - 18'h0_0001;
               if (r_reg.cnt == 18'h0_0001) begin
                  r_next.st = SPMC_RUN;
                  r_next.ctl1[`SPMC_STOP_BIT] = 1'b0;
               end
            end
         end
         SPMC_HALT: begin
            if (irq_req_i) begin
               r_next.ctl2[`SPMC_IDLE_BIT] = 1'b0;
               if (master_interrupt_enable_i) begin
                  r_next.st  = SPMC_ISR;
                  r_next.svc = 1'b1;
               end else begin
                  r_next.st = SPMC_RUN;
               end
            end
         end
         SPMC_ISR: begin
            r_next.st = SPMC_RUN;
         end
         default: r_next.st = SPMC_RUN;
      endcase
      // Halt flags registered with the state, so the halt outputs need no decode after the flops
      r_next.halt  = r_next.st != SPMC_RUN && r_next.st != SPMC_ISR;
      r_next.phalt = r_next.st == SPMC_STOP || r_next.st == SPMC_WARMUP;
   end

   // Synchronous reset returns to fast single-clock run from any mode
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r_reg          <= '0;
         r_reg.st       <= SPMC_RUN;
         r_reg.ctl1     <= `SPMC_SYSCTL1_RST;
         r_reg.ctl2     <= `SPMC_SYSCTL2_RST;
         r_reg.wken     <= `SPMC_WKEN_RST;
         r_reg.xen      <= 1'b1;
         r_reg.key_s1   <= '1;                                             // Released keys read high
         r_reg.key_s2   <= '1;
      end else begin
         r_reg <= r_next;
      end
   end

   // Outputs straight from flip-flops
   always_comb begin
      dat_o           = r_reg.dat;
      ack_o           = r_reg.ack;
      cpu_halt_o      = r_reg.halt;
      wdt_halt_o      = r_reg.halt;
      periph_halt_o   = r_reg.phalt;
      divider_clear_o = r_reg.clr;
      service_irq_o   = r_reg.svc;
      fast_osc_en_o   = r_reg.xen;
      slow_osc_en_o   = r_reg.xten;
      held_pc_o       = r_reg.pc;
      state_o         = r_reg.st;
   end

   // Level release with wake present must go straight to warm-up
   property p_level_skip;
      @(posedge clk_i) disable iff (rst_i)
      (r_reg.st == SPMC_RUN && r_reg.ctl1[`SPMC_STOP_BIT] && r_reg.release_level_select_eff && level_wake)
      |=> r_reg.st == SPMC_WARMUP;
   endproperty
   a_level_skip: assert property (p_level_skip) else $error("stop entered despite level wake");

   property p_edge_enter;
      @(posedge clk_i) disable iff (rst_i)
      (r_reg.st == SPMC_RUN && r_reg.ctl1[`SPMC_STOP_BIT] && !r_reg.release_level_select_eff) |=> r_reg.st == SPMC_STOP;
   endproperty
   a_edge_enter: assert property (p_edge_enter) else $error("edge mode did not enter stop");

   property p_edge_release;
      @(posedge clk_i) disable iff (rst_i)
      (r_reg.st == SPMC_STOP && !r_reg.release_level_select_eff && !wake_rise) |=> r_reg.st == SPMC_STOP;
   endproperty
   a_edge_release: assert property (p_edge_release) else $error("edge stop left without rise");

   property p_no_reenter;
      @(posedge clk_i) disable iff (rst_i)
      r_reg.st == SPMC_WARMUP |=> r_reg.st != SPMC_STOP;
   endproperty
   a_no_reenter: assert property (p_no_reenter) else $error("stop re-entered from warm-up");

   property p_release_level_select_switch;
      @(posedge clk_i) disable iff (rst_i)
      (!r_reg.release_level_select_eff && !wake_rise) |=> !r_reg.release_level_select_eff;
   endproperty
   a_release_level_select_switch: assert property (p_release_level_select_switch) else $error("level mode taken without edge");

   property p_pc_plus2;
      @(posedge clk_i) disable iff (rst_i)
      (r_reg.st == SPMC_RUN && r_reg.ctl2[`SPMC_IDLE_BIT] && !r_reg.ctl1[`SPMC_STOP_BIT])
      |=> r_reg.pc == $past(entry_pc_i) + 16'h0002;
   endproperty
   a_pc_plus2: assert property (p_pc_plus2) else $error("held pc not entry plus two");

   sequence s_wake_nomask;
      r_reg.st == SPMC_HALT && irq_req_i && !master_interrupt_enable_i;
   endsequence
   property p_normal_wake;
      @(posedge clk_i) disable iff (rst_i)
      s_wake_nomask |=> r_reg.st == SPMC_RUN && !r_reg.ctl2[`SPMC_IDLE_BIT] && !service_irq_o;
   endproperty
   a_normal_wake: assert property (p_normal_wake) else $error("halt wake without service failed");

   sequence s_wake_mask;
      r_reg.st == SPMC_HALT && irq_req_i && master_interrupt_enable_i;
   endsequence
   property p_isr_wake;
      @(posedge clk_i) disable iff (rst_i)
      s_wake_mask |=> service_irq_o ##1 r_reg.st == SPMC_RUN;
   endproperty
   a_isr_wake: assert property (p_isr_wake) else $error("serviced wake sequence wrong");

   property p_clear_div;
      @(posedge clk_i) disable iff (rst_i)
      (r_reg.st == SPMC_STOP) |=> divider_clear_o;
   endproperty
   a_clear_div: assert property (p_clear_div) else $error("divider not cleared in stop");

   property p_warm_halt;
      @(posedge clk_i) disable iff (rst_i)
      r_reg.st == SPMC_WARMUP |-> cpu_halt_o && periph_halt_o;
   endproperty
   a_warm_halt: assert property (p_warm_halt) else $error("operation during warm-up");

   // Reset lands in fast single-clock run from any mode, slow oscillator off
   property p_reset_run;
      @(posedge clk_i)
      rst_i |=> r_reg.st == SPMC_RUN && r_reg.xen && !r_reg.xten && !r_reg.halt;
   endproperty
   a_reset_run: assert property (p_reset_run) else $error("reset did not return to fast run");

   // Both oscillators stay off for the whole stop period
   property p_stop_osc;
      @(posedge clk_i) disable iff (rst_i)
      r_reg.st == SPMC_STOP |-> !fast_osc_en_o && !slow_osc_en_o;
   endproperty
   a_stop_osc: assert property (p_stop_osc) else $error("oscillator running in stop");

   // Release toward slow run restarts only the slow oscillator
   sequence s_release_slow;
      r_reg.st == SPMC_STOP && release_c && r_reg.ctl1[`SPMC_RETM_BIT];
   endsequence
   property p_slow_osc;
      @(posedge clk_i) disable iff (rst_i)
      s_release_slow |=> !fast_osc_en_o && slow_osc_en_o;
   endproperty
   a_slow_osc: assert property (p_slow_osc) else $error("slow return oscillators wrong");

   // Release toward fast run adds the slow oscillator only in dual-clock operation
   sequence s_release_fast;
      r_reg.st == SPMC_STOP && release_c && !r_reg.ctl1[`SPMC_RETM_BIT];
   endsequence
   property p_fast_osc;
      @(posedge clk_i) disable iff (rst_i)
      s_release_fast |=> fast_osc_en_o && slow_osc_en_o == $past(r_reg.ctl2[`SPMC_XTEN_BIT]);
   endproperty
   a_fast_osc: assert property (p_fast_osc) else $error("fast return oscillators wrong");

   // Without an oscillator tick the warm-up count must not move
   property p_warm_hold;
      @(posedge clk_i) disable iff (rst_i)
      (r_reg.st == SPMC_WARMUP && !osc_tick_i) |=> r_reg.st == SPMC_WARMUP && r_reg.cnt == $past(r_reg.cnt);
   endproperty
   a_warm_hold: assert property (p_warm_hold) else $error("warm-up moved without tick");

   // Each tick takes exactly one off the warm-up count
   property p_tick_count;
      @(posedge clk_i) disable iff (rst_i)
      (r_reg.st == SPMC_WARMUP && osc_tick_i && r_reg.cnt != 18'h0_0001) |=> r_reg.cnt == $past(r_reg.cnt) - 18'h0_0001;
   endproperty
   a_tick_count: assert property (p_tick_count) else $error("warm-up tick not counted");

   // Last tick resumes execution with the stop request withdrawn
   property p_warm_done;
      @(posedge clk_i) disable iff (rst_i)
      (r_reg.st == SPMC_WARMUP && osc_tick_i && r_reg.cnt == 18'h0_0001) |=> r_reg.st == SPMC_RUN && !r_reg.ctl1[`SPMC_STOP_BIT];
   endproperty
   a_warm_done: assert property (p_warm_done) else $error("warm-up end did not resume");

   // Halt stops the CPU and watchdog while peripherals keep running
   property p_halt_out;
      @(posedge clk_i) disable iff (rst_i)
      r_reg.st == SPMC_HALT |-> cpu_halt_o && wdt_halt_o && !periph_halt_o;
   endproperty
   a_halt_out: assert property (p_halt_out) else $error("halt outputs wrong");

endmodule : spmc_ctrl

// File: dv/spmc_wake_model.sv
/*
 Far-side model: wake pin, key-wakeup lines and the oscillator being warmed up.
 Assumes the bench sets the wanted levels; all pins change just after a rising edge.
*/
`timescale 1ns/1ps
module spmc_wake_model (
   // Clock
   input  wire logic       clk_i,
   // Wanted levels from the bench
   input  wire logic       wake_lvl_i,
   input  wire logic [3:0] key_press_i,
   input  wire logic       osc_on_i,
   // Pins toward the sequencer
   output logic            wake_pin_o,
   output logic [3:0]      keys_o,
   output logic            osc_tick_o
);
   // Defined levels before the first edge
   initial begin
      wake_pin_o = 1'b0;
      keys_o     = 4'hF;
      osc_tick_o = 1'b0;
   end
   // Keys are pulled up, so a released key reads high; no tick while both oscillators are off
   always @(posedge clk_i) begin
      wake_pin_o <= wake_lvl_i;
      keys_o     <= ~key_press_i;
      osc_tick_o <= osc_on_i;
   end
endmodule : spmc_wake_model

// File: dv/tb.sv
/*
 Self-checking bench for the stop/idle/sleep sequencer.
 Assumes the design package and the far-side model are compiled first.
*/
`timescale 1ns/1ps
module tb;
   import spmc_pkg::*;
   localparam int LIMIT = 40000;
   logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [3:0]  adr_i = 4'h0, key_press = 4'h0, keys;
   logic [31:0] dat_i = 32'h0000_0000, dat_o;
   logic        ack_o, wake_lvl = 1'b0, irq_req_i = 1'b0, mie_i = 1'b0;
   logic [3:0]  sel_i = 4'h0;
   logic [15:0] entry_pc = 16'h1234;
   logic        wake_pin_i, osc_tick_i, cpu_halt_o, wdt_halt_o, periph_halt_o, divider_clear_o;
   logic        service_irq_o, fast_osc_en_o, slow_osc_en_o;
   logic [15:0] held_pc_o;
   logic [7:0]  rd;
   spmc_state_t state_o;
   int          miscompares = 0, checked = 0, cycles = 0, n, stops = 0, svcs = 0, base;

   // Free-running 125 MHz clock
   always #4 clk_i = ~clk_i;

   spmc_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
      .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .wake_pin_i(wake_pin_i),
      .key_wakeup_inputs_i(keys), .irq_req_i(irq_req_i), .master_interrupt_enable_i(mie_i),
      .osc_tick_i(osc_tick_i), .entry_pc_i(entry_pc), .cpu_halt_o(cpu_halt_o), .wdt_halt_o(wdt_halt_o),
      .periph_halt_o(periph_halt_o), .divider_clear_o(divider_clear_o), .service_irq_o(service_irq_o),
      .fast_osc_en_o(fast_osc_en_o), .slow_osc_en_o(slow_osc_en_o), .held_pc_o(held_pc_o), .state_o(state_o));

   spmc_wake_model far (.clk_i(clk_i), .wake_lvl_i(wake_lvl), .key_press_i(key_press),
      .osc_on_i(fast_osc_en_o | slow_osc_en_o), .wake_pin_o(wake_pin_i), .keys_o(keys), .osc_tick_o(osc_tick_i));

   // Sticky watchers and the hang guard
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (state_o === SPMC_STOP) stops <= stops + 1;
      if (service_irq_o === 1'b1) svcs <= svcs + 1;
      if (cycles == LIMIT) begin
         miscompares++;
         finish_test();
      end
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // Classic single cycle; read data taken at the ack edge
   task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      sel_i <= 4'h1;
      adr_i <= a;
      dat_i <= {24'h00_0000, d};
      do @(posedge clk_i); while (ack_o !== 1'b1);
      rd = dat_o[7:0];
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask : wb

   // Bounded wait for a state; k counts the edges spent waiting
   task automatic wait_st(input spmc_state_t s, output int k);
      k = 0;
      while (state_o !== s && k < 20000) begin
         @(posedge clk_i);
         k++;
      end
      chk("state", state_o, s);
   endtask : wait_st

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : finish_test

   // Main sequence
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(0, 4'h0, 8'h00); chk("ctl1", rd, 8'h00);
      wb(0, 4'h4, 8'h00); chk("ctl2", rd, 8'h80);
      wb(0, 4'hC, 8'h00); chk("status", rd, SPMC_RUN);
      wb(1, 4'h2, 8'hFF); wb(0, 4'h2, 8'h00); chk("unmapped", rd, 8'h00);
      // Edge release: stop entered with wake high, only a rise releases
      // Let the rise pass the synchroniser while still running, so stop sees only a steady high
      wake_lvl <= 1'b1;
      repeat (4) @(posedge clk_i);
      wb(1, 4'h0, 8'hAC); wait_st(SPMC_STOP, n);
      chk("osc off", {fast_osc_en_o, slow_osc_en_o}, 2'b00);
      wake_lvl <= 1'b0;
      repeat (8) @(posedge clk_i);
      chk("no level release", state_o, SPMC_STOP);
      wake_lvl <= 1'b1;
      wait_st(SPMC_WARMUP, n);
      chk("slow return osc", {fast_osc_en_o, slow_osc_en_o}, 2'b01);
      chk("warm-up halt", {cpu_halt_o, periph_halt_o}, 2'b11);
      wait_st(SPMC_RUN, n); chk("warm-up length", n >= 64 && n <= 68, 1);
      chk("divider clear", divider_clear_o, 1'b1);
      wb(0, 4'h0, 8'h00); chk("stop bit cleared", rd, 8'h2C);
      // Level selected while wake is already high: edge behaviour until a rise
      wb(1, 4'h0, 8'hEC); wait_st(SPMC_STOP, n);
      wake_lvl <= 1'b0;
      repeat (6) @(posedge clk_i);
      wake_lvl <= 1'b1;
      wait_st(SPMC_WARMUP, n); wait_st(SPMC_RUN, n);
      // Level mode with wake present: warm-up at once, no re-entry when wake drops
      base = stops;
      wb(1, 4'h0, 8'hEC); wait_st(SPMC_WARMUP, n);
      chk("skipped stop", stops - base, 0);
      wake_lvl <= 1'b0;
      wait_st(SPMC_RUN, n); chk("no re-entry", stops - base, 0);
      // Key release, return to fast; a disabled key must not release
      wb(1, 4'h8, 8'h01);
      wb(1, 4'h0, 8'hCC); wait_st(SPMC_STOP, n);
      key_press <= 4'h2;
      repeat (8) @(posedge clk_i);
      chk("disabled key", state_o, SPMC_STOP);
      key_press <= 4'h1;
      wait_st(SPMC_WARMUP, n);
      chk("fast return osc", {fast_osc_en_o, slow_osc_en_o}, 2'b10);
      key_press <= 4'h0;
      wait_st(SPMC_RUN, n);
      // Dual clock, fast return: both oscillators restart; a reset cuts the warm-up short
      wb(1, 4'h4, 8'hC0);
      wb(1, 4'h0, 8'h8C); wait_st(SPMC_STOP, n);
      wake_lvl <= 1'b1;
      wait_st(SPMC_WARMUP, n);
      chk("dual return osc", {fast_osc_en_o, slow_osc_en_o}, 2'b11);
      wake_lvl <= 1'b0;
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      chk("reset out of warm-up", state_o, SPMC_RUN);
      // Reset during stop
      wb(1, 4'h0, 8'hAC); wait_st(SPMC_STOP, n);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      chk("reset out of stop", state_o, SPMC_RUN);
      chk("reset osc", {fast_osc_en_o, slow_osc_en_o}, 2'b10);
      // Idle with master enable clear: wake without service
      base = svcs;
      wb(1, 4'h4, 8'h90); wait_st(SPMC_HALT, n);
      chk("halt outputs", {cpu_halt_o, wdt_halt_o, periph_halt_o}, 3'b110);
      chk("held pc", held_pc_o, 16'h1236);
      irq_req_i <= 1'b1;
      wait_st(SPMC_RUN, n); chk("no service", svcs - base, 0);
      irq_req_i <= 1'b0;
      wb(0, 4'h4, 8'h00); chk("idle cleared", rd, 8'h80);
      // Idle with master enable set: service, then run
      mie_i <= 1'b1;
      entry_pc <= 16'h4FFE;
      base = svcs;
      wb(1, 4'h4, 8'h90); wait_st(SPMC_HALT, n);
      chk("held pc second", held_pc_o, 16'h5000);
      irq_req_i <= 1'b1;
      wait_st(SPMC_ISR, n); wait_st(SPMC_RUN, n);
      chk("serviced", svcs - base, 1);
      irq_req_i <= 1'b0;
      mie_i <= 1'b0;
      finish_test();
   end
endmodule : tb
